/* rtl/tss_pkg.sv */
// Constants and carrier types for the temperature sensor serial slave.
// Assumes one core clock at 100 MHz and a free-running link sampling clock.
//
// Overview of operation
// - Local temperature is 10-bit signed, 0.25 C steps, left-justified, low bits zero.
// - Local readings above +127.75 C clamp to the +127.75 C code.
// - Filtered unsigned remote word steps 0008h per 0.03125 C; top reading FFE0h.
// - A faulty remote diode reads -128.000 C signed or +255.875 C unsigned.
// - A faulty remote diode also sets its missing flag in status bit D0 or D1.
// - An internal pointer selects the register; it resets to 00, local temperature.
// - The pointer keeps its last written value until a new command byte arrives.
// - Each register is read only, write only, or read and write.
// - A write is address byte, command byte, then exactly one data byte.
// - With the pointer preset, a read is the address byte then the data byte.
// - Another location is read by address, command, repeated start, address with read.
// - Every data byte travels most significant bit first.
// - After a read byte the master may acknowledge or not; not ends the read.
// - Reading a high temperature byte freezes its low byte until that is read.
// - Each further high byte read recaptures the low byte of the newer result.
// - The bus engine returns to idle when a line stays low over 35 ms.
// - A start condition anywhere abandons the transfer; an address byte follows.
// - A one-shot write in standby runs one conversion; its data is not stored.
// - A read of the one-shot location returns zero.
// - The command byte carries the eight pointer bits into the pointer.
// - The device is a pure slave: it never drives or stretches the clock line.
// - The device answers one fixed seven-bit slave address.
// - A one-shot converts all three channels and acts only in standby.

package tss_pkg;

  // ----------------------------------------------------------------
  // Identity and register map
  // ----------------------------------------------------------------
  // Slave address value is arbitrary.
  localparam logic [6:0] SLAVE_ADDR = 7'h1d;

  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] REG_LOC_MSB_ALT = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h03;
  localparam logic [7:0] REG_ONE_SHOT = 8'h0f;
  localparam logic [7:0] REG_LOC_MSB = 8'h10;
  localparam logic [7:0] REG_R1_MSB = 8'h11;
  localparam logic [7:0] REG_R2_MSB = 8'h12;
  localparam logic [7:0] REG_LOC_LSB = 8'h20;
  localparam logic [7:0] REG_R1_LSB = 8'h21;
  localparam logic [7:0] REG_R2_LSB = 8'h22;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_UNSIGNED_BIT = 3;
  localparam int STAT_BUSY_BIT = 7;

  // ----------------------------------------------------------------
  // Temperature codes
  // ----------------------------------------------------------------
  localparam logic signed [11:0] LOC_MAX = 12'sh1ff;
  localparam logic signed [11:0] LOC_MIN = -12'sh200;
  localparam logic signed [13:0] REM_S_MAX = 14'sh0fff;
  localparam logic signed [13:0] REM_S_MIN = -14'sh1000;
  localparam logic signed [13:0] REM_U_MAX = 14'sh1ffc;
  localparam logic [15:0] FAULT_SIGNED = 16'h8000;
  localparam logic [15:0] FAULT_UNSIGNED = 16'hffe0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_MS = 35;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int TO_W = 22;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] loc;
    logic [15:0] r1;
    logic [15:0] r2;
    logic [1:0] missing;
  } tss_snap_t;

  typedef enum logic [9:0] {
    ST_IDLE = 10'b00_0000_0001,
    ST_ADDR = 10'b00_0000_0010,
    ST_ACK_A = 10'b00_0000_0100,
    ST_CMD = 10'b00_0000_1000,
    ST_ACK_C = 10'b00_0001_0000,
    ST_WDAT = 10'b00_0010_0000,
    ST_ACK_W = 10'b00_0100_0000,
    ST_TX = 10'b00_1000_0000,
    ST_MACK = 10'b01_0000_0000,
    ST_IGNR = 10'b10_0000_0000
  } tss_state_t;

endpackage

/* rtl/tss_smbus_slave.sv */
// Serial slave access logic of a three-channel temperature sensor.
// Assumes the measurement engine on MCLK and external pull-ups on both bus lines.
`timescale 1ns/100ps
`default_nettype none

module tss_smbus_slave
  import tss_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic LINK_CLK,
  input wire logic SMBCLK,
  input wire logic SMBDAT_I,
  output logic SMBDAT_O,
  output logic SMBDAT_OE,
  output logic CONV_START,
  output logic BUSY,
  input wire logic CONV_DONE,
  input wire logic [11:0] LOCAL_TEMP,
  input wire logic [13:0] REM1_TEMP,
  input wire logic [13:0] REM2_TEMP,
  input wire logic [1:0] REM_FAULT
);

  // ----------------------------------------------------------------
  // Core domain: configuration, one-shot and timeout synchronisers
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  logic os_tgl_q;
  logic [1:0] standby_s_q;
  logic [1:0] unsigned_s_q;
  logic [1:0] os_s_q;
  logic os_p_q;
  logic [1:0] scl_m_q;
  logic [1:0] sda_m_q;
  logic rq_ack_q;
  logic [1:0] ack_s_q;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      standby_s_q <= '0;
      unsigned_s_q <= '0;
      os_s_q <= '0;
      scl_m_q <= 2'b11;
      sda_m_q <= 2'b11;
      ack_s_q <= '0;
    end
    else
    begin
      standby_s_q <= {standby_s_q[0], cfg_q[CFG_STANDBY_BIT]};
      unsigned_s_q <= {unsigned_s_q[0], cfg_q[CFG_UNSIGNED_BIT]};
      os_s_q <= {os_s_q[0], os_tgl_q};
      scl_m_q <= {scl_m_q[0], SMBCLK};
      sda_m_q <= {sda_m_q[0], SMBDAT_I};
      ack_s_q <= {ack_s_q[0], rq_ack_q};
    end
  end

  // ----------------------------------------------------------------
  // Core domain: bus timeout
  // ----------------------------------------------------------------
  // Counting on the core clock keeps the limit exact whatever the link clock rate.
  logic [TO_W-1:0] to_cnt_q;
  logic to_tgl_q;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      to_cnt_q <= '0;
      to_tgl_q <= 1'b0;
    end
    else if (CE)
    begin
      if (scl_m_q[1] && sda_m_q[1])
        to_cnt_q <= '0;
      else if (to_cnt_q != TO_W'(TIMEOUT_CYCLES))
      begin
        to_cnt_q <= to_cnt_q + TO_W'(1);
        if (to_cnt_q == TO_W'(TIMEOUT_CYCLES - 1))
          to_tgl_q <= ~to_tgl_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: conversion sequencing
  // ----------------------------------------------------------------
  logic os_hit;
  logic start_now;

  assign os_hit = os_s_q[1] ^ os_p_q;
  // Continuous mode restarts at once; standby starts only on a one-shot write.
  assign start_now = !BUSY && (standby_s_q[1] ? os_hit : 1'b1);

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      os_p_q <= 1'b0;
      BUSY <= 1'b0;
      CONV_START <= 1'b0;
    end
    else if (CE)
    begin
      os_p_q <= os_s_q[1];
      CONV_START <= start_now;
      if (start_now)
        BUSY <= 1'b1;
      else if (CONV_DONE)
        BUSY <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: result encoding and hand-off
  // ----------------------------------------------------------------
  function automatic logic [15:0] enc_remote(input logic [13:0] raw, input logic fault,
                                             input logic uns);
    logic signed [13:0] t;
    logic [15:0] w;
    t = $signed(raw);
    w = '0;
    if (fault)
      w = uns ? FAULT_UNSIGNED : FAULT_SIGNED;
    else if (uns)
    begin
      if (t < 14'sd0)
        w = '0;
      else if (t > REM_U_MAX)
        w = {REM_U_MAX[12:0], 3'b000};
      else
        w = {t[12:0], 3'b000};
    end
    else if (t > REM_S_MAX)
      w = {REM_S_MAX[12:0], 3'b000};
    else if (t < REM_S_MIN)
      w = {REM_S_MIN[12:0], 3'b000};
    else
      w = {t[12:0], 3'b000};
    return w;
  endfunction

  function automatic logic [15:0] enc_local(input logic [11:0] raw);
    logic signed [11:0] t;
    logic [15:0] w;
    t = $signed(raw);
    if (t > LOC_MAX)
      w = {LOC_MAX[9:0], 6'b00_0000};
    else if (t < LOC_MIN)
      w = {LOC_MIN[9:0], 6'b00_0000};
    else
      w = {t[9:0], 6'b00_0000};
    return w;
  endfunction

  tss_snap_t snap_hold_q;
  logic rq_tgl_q;

  // A result finishing while the previous one is still crossing is dropped;
  // the link is far faster than a conversion, so this never happens in use.
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      snap_hold_q <= '0;
      rq_tgl_q <= 1'b0;
    end
    else if (CE && CONV_DONE && BUSY && (ack_s_q[1] == rq_tgl_q))
    begin
      snap_hold_q.loc <= enc_local(LOCAL_TEMP);
      snap_hold_q.r1 <= enc_remote(REM1_TEMP, REM_FAULT[0], unsigned_s_q[1]);
      snap_hold_q.r2 <= enc_remote(REM2_TEMP, REM_FAULT[1], unsigned_s_q[1]);
      snap_hold_q.missing <= REM_FAULT;
      rq_tgl_q <= ~rq_tgl_q;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: synchronisers and bus events
  // ----------------------------------------------------------------
  logic [1:0] ce_l_q;
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic [1:0] to_s_q;
  logic [1:0] rq_s_q;
  logic [1:0] busy_s_q;
  logic scl_p_q;
  logic sda_p_q;
  logic to_p_q;
  logic ce_l;

  assign ce_l = ce_l_q[1];

  always_ff @(posedge LINK_CLK or posedge RST)
  begin
    if (RST)
    begin
      ce_l_q <= '0;
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      to_s_q <= '0;
      rq_s_q <= '0;
      busy_s_q <= '0;
    end
    else
    begin
      ce_l_q <= {ce_l_q[0], CE};
      scl_s_q <= {scl_s_q[0], SMBCLK};
      sda_s_q <= {sda_s_q[0], SMBDAT_I};
      to_s_q <= {to_s_q[0], to_tgl_q};
      rq_s_q <= {rq_s_q[0], rq_tgl_q};
      busy_s_q <= {busy_s_q[0], BUSY};
    end
  end

  always_ff @(posedge LINK_CLK or posedge RST)
  begin
    if (RST)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      to_p_q <= 1'b0;
    end
    else if (ce_l)
    begin
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
      to_p_q <= to_s_q[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic bus_abort;

  assign scl_rise = scl_s_q[1] && !scl_p_q;
  assign scl_fall = !scl_s_q[1] && scl_p_q;
  assign bus_start = scl_s_q[1] && scl_p_q && sda_p_q && !sda_s_q[1];
  assign bus_stop = scl_s_q[1] && scl_p_q && !sda_p_q && sda_s_q[1];
  assign bus_abort = to_s_q[1] ^ to_p_q;

  // ----------------------------------------------------------------
  // Link domain: result snapshot
  // ----------------------------------------------------------------
  tss_snap_t snap_q;

  always_ff @(posedge LINK_CLK or posedge RST)
  begin
    if (RST)
    begin
      snap_q <= '0;
      rq_ack_q <= 1'b0;
    end
    else if (ce_l && (rq_s_q[1] != rq_ack_q))
    begin
      snap_q <= snap_hold_q;
      rq_ack_q <= rq_s_q[1];
    end
  end

  // ----------------------------------------------------------------
  // Link domain: byte engine
  // ----------------------------------------------------------------
  tss_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic rw_q;
  logic [7:0] ptr_q;
  logic byte_done;
  logic tx_load;
  logic [7:0] rd_data;

  assign byte_done = scl_fall && (cnt_q == 4'd8);
  assign tx_load = scl_fall && (((state_q == ST_ACK_A) && rw_q) || (state_q == ST_MACK));

  always_ff @(posedge LINK_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      rw_q <= 1'b0;
      SMBDAT_OE <= 1'b0;
    end
    else if (ce_l)
    begin
      if (bus_abort)
      begin
        state_q <= ST_IDLE;
        SMBDAT_OE <= 1'b0;
      end
      else if (bus_start)
      begin
        state_q <= ST_ADDR;
        cnt_q <= '0;
        SMBDAT_OE <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_q <= ST_IDLE;
        SMBDAT_OE <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          ST_IDLE, ST_IGNR:
            SMBDAT_OE <= 1'b0;
          ST_ADDR, ST_CMD, ST_WDAT:
          begin
            if (scl_rise)
            begin
              sh_q <= {sh_q[6:0], sda_s_q[1]};
              cnt_q <= cnt_q + 4'd1;
            end
            else if (byte_done)
            begin
              cnt_q <= '0;
              if (state_q == ST_ADDR)
              begin
                rw_q <= sh_q[0];
                if (sh_q[7:1] == SLAVE_ADDR)
                begin
                  state_q <= ST_ACK_A;
                  SMBDAT_OE <= 1'b1;
                end
                else
                  state_q <= ST_IGNR;
              end
              else
              begin
                state_q <= (state_q == ST_CMD) ? ST_ACK_C : ST_ACK_W;
                SMBDAT_OE <= 1'b1;
              end
            end
          end
          ST_ACK_A, ST_ACK_C, ST_ACK_W:
          begin
            if (scl_fall)
            begin
              if (tx_load)
              begin
                state_q <= ST_TX;
                sh_q <= rd_data;
                SMBDAT_OE <= ~rd_data[7];
              end
              else
              begin
                SMBDAT_OE <= 1'b0;
                // A further byte after the single data byte is refused.
                state_q <= (state_q == ST_ACK_A) ? ST_CMD :
                           (state_q == ST_ACK_C) ? ST_WDAT : ST_IGNR;
              end
            end
          end
          ST_TX:
          begin
            if (scl_rise)
              cnt_q <= cnt_q + 4'd1;
            else if (byte_done)
            begin
              cnt_q <= '0;
              SMBDAT_OE <= 1'b0;
              state_q <= ST_MACK;
            end
            else if (scl_fall)
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              SMBDAT_OE <= ~sh_q[6];
            end
          end
          ST_MACK:
          begin
            if (scl_rise && sda_s_q[1])
              state_q <= ST_IGNR;
            else if (tx_load)
            begin
              state_q <= ST_TX;
              sh_q <= rd_data;
              SMBDAT_OE <= ~rd_data[7];
            end
          end
        endcase
      end
    end
  end

  // Only the low level is ever driven; the clock line has no driver at all.
  always_ff @(posedge LINK_CLK or posedge RST)
  begin
    if (RST)
      SMBDAT_O <= 1'b0;
    else
      SMBDAT_O <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Link domain: pointer, configuration and one-shot writes
  // ----------------------------------------------------------------
  logic cmd_take;
  logic data_take;

  assign cmd_take = ce_l && !bus_abort && !bus_start && !bus_stop && (state_q == ST_CMD)
                    && byte_done;
  assign data_take = ce_l && !bus_abort && !bus_start && !bus_stop && (state_q == ST_WDAT)
                     && byte_done;

  always_ff @(posedge LINK_CLK or posedge RST)
  begin
    if (RST)
    begin
      ptr_q <= PTR_RESET;
      cfg_q <= CONFIG_RESET;
      os_tgl_q <= 1'b0;
    end
    else
    begin
      if (cmd_take)
        ptr_q <= sh_q;
      if (data_take)
      begin
        // Read-only targets are acknowledged but left unchanged.
        if (ptr_q == REG_CONFIG)
          cfg_q <= sh_q;
        else if (ptr_q == REG_ONE_SHOT)
          os_tgl_q <= ~os_tgl_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: read data and low-byte freeze
  // ----------------------------------------------------------------
  // One flag per channel, each written only by its own generate block.
  logic frz_q [3];
  logic [7:0] frz_byte_q [3];
  logic [15:0] live_word [3];

  assign live_word[0] = snap_q.loc;
  assign live_word[1] = snap_q.r1;
  assign live_word[2] = snap_q.r2;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_freeze
      logic msb_rd;
      logic lsb_rd;
      assign msb_rd = tx_load && ce_l && !bus_abort && !bus_start && !bus_stop
                      && ((ptr_q == REG_LOC_MSB + 8'(ch))
                          || ((ch == 0) && (ptr_q == REG_LOC_MSB_ALT)));
      assign lsb_rd = tx_load && ce_l && !bus_abort && !bus_start && !bus_stop
                      && (ptr_q == REG_LOC_LSB + 8'(ch));
      always_ff @(posedge LINK_CLK or posedge RST)
      begin
        if (RST)
        begin
          frz_q[ch] <= 1'b0;
          frz_byte_q[ch] <= '0;
        end
        else if (msb_rd)
        begin
          frz_q[ch] <= 1'b1;
          frz_byte_q[ch] <= live_word[ch][7:0];
        end
        else if (lsb_rd)
          frz_q[ch] <= 1'b0;
      end
    end
  endgenerate

  always_comb
  begin
    rd_data = 8'h00;
    unique case (ptr_q)
      REG_LOC_MSB_ALT, REG_LOC_MSB: rd_data = snap_q.loc[15:8];
      REG_R1_MSB: rd_data = snap_q.r1[15:8];
      REG_R2_MSB: rd_data = snap_q.r2[15:8];
      REG_LOC_LSB: rd_data = frz_q[0] ? frz_byte_q[0] : snap_q.loc[7:0];
      REG_R1_LSB: rd_data = frz_q[1] ? frz_byte_q[1] : snap_q.r1[7:0];
      REG_R2_LSB: rd_data = frz_q[2] ? frz_byte_q[2] : snap_q.r2[7:0];
      REG_STATUS: rd_data = {busy_s_q[1], 5'b0_0000, snap_q.missing};
      REG_CONFIG: rd_data = cfg_q;
      REG_ONE_SHOT: rd_data = 8'h00;
      default: rd_data = 8'h00;
    endcase
  end

endmodule

`default_nettype wire

/* tb/tss_smbus_master.sv */
// Host side of the two-wire bus, driven by tasks called from the bench.
// Assumes the bench builds the pulled-up data wire from every enable.
`timescale 1ns/100ps
`default_nettype none

module tss_smbus_master
(
  input wire logic clk,
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // Five clocks a quarter bit keep both clock phases far above the slave's need.
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bitx(input logic b, output logic r);
    sda_oe <= !b;
    tick(5);
    scl <= 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl <= 1'b0;
    tick(5);
  endtask

  task automatic start_c();
    sda_oe <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_oe <= 1'b1;
    tick(5);
    scl <= 1'b0;
    tick(5);
  endtask

  task automatic stop_c();
    sda_oe <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_oe <= 1'b0;
    tick(5);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r);
    bitx(1'b1, nack);
  endtask

  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, b[i]);
    bitx(nack, r);
  endtask

  task automatic hold_low(input int n);
    tick(n);
  endtask
endmodule

`default_nettype wire

/* tb/tss_smbus_slave_props.sv */
// Concurrent checks on the ports of the temperature sensor serial slave.
// Assumes the bus lines as seen at the pins and a bench that drives a real timeout.
`timescale 1ns/100ps
`default_nettype none

module tss_smbus_slave_props
#(
  parameter int unsigned TIMEOUT_CYCLES = 200
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic SMBCLK,
  input wire logic SMBDAT_I,
  input wire logic SMBDAT_O,
  input wire logic SMBDAT_OE,
  input wire logic CONV_START,
  input wire logic BUSY,
  input wire logic CONV_DONE
);
  // Twenty spare cycles cover the synchronisers on the way to the data line.
  logic [31:0] low_cnt_q;

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      low_cnt_q <= 32'h0000_0000;
    else if (SMBCLK && SMBDAT_I)
      low_cnt_q <= 32'h0000_0000;
    else
      low_cnt_q <= low_cnt_q + 32'h0000_0001;
  end

  chk_od_low_only: assert property (@(posedge LINK_CLK) disable iff (RST)
    SMBDAT_O == 1'b0) else $error("Data output not open drain.");
  chk_oe_scl_low: assert property (@(posedge LINK_CLK) disable iff (RST)
    $changed(SMBDAT_OE) |-> !SMBCLK) else $error("Data changed with clock high.");
  chk_start_pulse: assert property (@(posedge MCLK) disable iff (RST)
    CONV_START |=> !CONV_START) else $error("Start pulse too long.");
  chk_busy_with_start: assert property (@(posedge MCLK) disable iff (RST)
    CONV_START |-> BUSY) else $error("Busy not set with start.");
  chk_start_when_idle: assert property (@(posedge MCLK) disable iff (RST)
    CONV_START |-> !$past(BUSY)) else $error("Start while busy.");
  chk_busy_holds: assert property (@(posedge MCLK) disable iff (RST)
    BUSY && !CONV_DONE |=> BUSY) else $error("Busy dropped early.");
  chk_busy_clears: assert property (@(posedge MCLK) disable iff (RST)
    BUSY && CONV_DONE |=> !BUSY) else $error("Busy not cleared.");
  chk_bus_timeout: assert property (@(posedge MCLK) disable iff (RST)
    (low_cnt_q > TIMEOUT_CYCLES + 32'd20) |-> !SMBDAT_OE) else $error("No timeout release.");
endmodule

bind tss_smbus_slave tss_smbus_slave_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .MCLK(MCLK),
  .RST(RST),
  .LINK_CLK(LINK_CLK),
  .SMBCLK(SMBCLK),
  .SMBDAT_I(SMBDAT_I),
  .SMBDAT_O(SMBDAT_O),
  .SMBDAT_OE(SMBDAT_OE),
  .CONV_START(CONV_START),
  .BUSY(BUSY),
  .CONV_DONE(CONV_DONE)
);

`default_nettype wire

/* tb/tss_smbus_slave_tb.sv */
// Self-checking bench for the temperature sensor serial slave.
// Assumes the host model and a simple conversion engine standing in for the analog side.
`timescale 1ns/100ps
`default_nettype none

module tss_smbus_slave_tb
  import tss_pkg::*;
();
  localparam logic [7:0] AW = {SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AR = {SLAVE_ADDR, 1'b1};
  localparam logic [11:0] LT [3] = '{12'h064, 12'hfff, 12'h7ff};
  localparam logic [13:0] RT [3] = '{14'h0001, 14'h1ffc, 14'h0321};
  localparam logic [15:0] LW [3] = '{16'h1900, 16'hffc0, 16'h7fc0};
  localparam logic [15:0] RW [3] = '{16'h0008, 16'hffe0, 16'h1908};
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic conv_done = 1'b0;
  logic [4:0] cnt = 5'h00;
  logic [11:0] loc_t = 12'h064;
  logic [13:0] r1_t = 14'h0000;
  logic [13:0] r2_t = 14'h0100;
  logic [1:0] flt = 2'b00;
  int starts = 0;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  wire scl;
  wire m_oe;
  wire dat_oe;
  wire conv_start;
  wire busy;
  wire sda_w = !(m_oe || dat_oe);

  always #5 mclk = !mclk;

  initial
  begin
    #1.7;
    forever #3 link_clk = !link_clk;
  end

  tss_smbus_master u_mst (.clk(mclk), .scl(scl), .sda_oe(m_oe), .sda(sda_w));

  tss_smbus_slave #(.TIMEOUT_CYCLES(200)) u_dut (
    .MCLK(mclk),
    .RST(rst),
    .CE(1'b1),
    .LINK_CLK(link_clk),
    .SMBCLK(scl),
    .SMBDAT_I(sda_w),
    .SMBDAT_O(),
    .SMBDAT_OE(dat_oe),
    .CONV_START(conv_start),
    .BUSY(busy),
    .CONV_DONE(conv_done),
    .LOCAL_TEMP(loc_t),
    .REM1_TEMP(r1_t),
    .REM2_TEMP(r2_t),
    .REM_FAULT(flt)
  );

  // --------------------------------------------------------------
  // Conversion engine stand-in and watchdog
  // --------------------------------------------------------------
  always @(posedge mclk)
  begin
    conv_done <= 1'b0;
    cyc <= cyc + 1;
    if (conv_start === 1'b1)
    begin
      cnt <= 5'd20;
      starts <= starts + 1;
    end
    else if (cnt != 5'd0)
    begin
      cnt <= cnt - 5'd1;
      conv_done <= (cnt == 5'd1);
    end
    if (cyc == 80000)
    begin
      errors++;
      end_sim();
    end
  end

  // --------------------------------------------------------------
  // Bus access and check tasks
  // --------------------------------------------------------------
  task automatic end_sim();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
    logic n1;
    logic n2;
    logic n3;
    u_mst.start_c();
    u_mst.wbyte(AW, n1);
    u_mst.wbyte(p, n2);
    u_mst.wbyte(d, n3);
    u_mst.stop_c();
    chk(16'({n1, n2, n3}), 16'h0000);
  endtask

  task automatic reg_rd(input logic [7:0] p, output logic [7:0] d);
    logic n;
    u_mst.start_c();
    u_mst.wbyte(AW, n);
    u_mst.wbyte(p, n);
    u_mst.start_c();
    u_mst.wbyte(AR, n);
    u_mst.rbyte(d, 1'b1);
    u_mst.stop_c();
  endtask

  task automatic rd_cur(output logic [7:0] d);
    logic n;
    u_mst.start_c();
    u_mst.wbyte(AR, n);
    u_mst.rbyte(d, 1'b1);
    u_mst.stop_c();
  endtask

  task automatic rd_word(input logic [7:0] p, output logic [15:0] w);
    reg_rd(p, w[15:8]);
    reg_rd(p + 8'h10, w[7:0]);
  endtask

  task automatic set_t(input logic [11:0] l, input logic [13:0] r, input logic [1:0] f);
    @(posedge mclk);
    loc_t <= l;
    r1_t <= r;
    flt <= f;
    repeat (2) @(posedge conv_done);
    repeat (20) @(posedge mclk);
  endtask

  initial
  begin
    logic [7:0] d;
    logic [7:0] d2;
    logic [15:0] w;
    logic n;
    int n0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    set_t(12'h064, 14'h0000, 2'b00);
    rd_cur(d);
    chk(16'(d), 16'h0019);
    reg_wr(REG_CONFIG, 8'h08);
    for (int i = 0; i < 3; i++)
    begin
      set_t(LT[i], RT[i], 2'b00);
      rd_word(REG_LOC_MSB, w);
      chk(w, LW[i]);
      rd_word(REG_R1_MSB, w);
      chk(w, RW[i]);
    end
    set_t(12'h064, 14'h0321, 2'b10);
    rd_word(REG_R2_MSB, w);
    chk(w, 16'hffe0);
    reg_rd(REG_STATUS, d);
    chk(16'(d & 8'h7f), 16'h0002);
    reg_wr(REG_CONFIG, 8'h00);
    set_t(12'h064, 14'h0321, 2'b01);
    rd_word(REG_R1_MSB, w);
    chk(w, 16'h8000);
    reg_rd(REG_STATUS, d);
    chk(16'(d & 8'h7f), 16'h0001);
    set_t(12'h064, 14'h0321, 2'b00);
    reg_rd(REG_R1_MSB, d);
    chk(16'(d), 16'h0019);
    set_t(12'h064, 14'h0a55, 2'b00);
    rd_cur(d);
    chk(16'(d), 16'h0052);
    set_t(12'h064, 14'h0013, 2'b00);
    reg_rd(REG_R1_LSB, d);
    chk(16'(d), 16'h00a8);
    rd_cur(d);
    chk(16'(d), 16'h0098);
    u_mst.start_c();
    u_mst.wbyte(AW, n);
    u_mst.wbyte(REG_CONFIG, n);
    u_mst.wbyte(8'h08, n);
    chk(16'(n), 16'h0000);
    u_mst.wbyte(8'h00, n);
    chk(16'(n), 16'h0001);
    u_mst.stop_c();
    u_mst.start_c();
    u_mst.wbyte(AR, n);
    u_mst.rbyte(d, 1'b0);
    u_mst.rbyte(d2, 1'b1);
    u_mst.stop_c();
    chk({d, d2}, 16'h0808);
    u_mst.start_c();
    u_mst.wbyte({SLAVE_ADDR ^ 7'h01, 1'b1}, n);
    u_mst.stop_c();
    chk(16'(n), 16'h0001);
    u_mst.start_c();
    u_mst.wbyte(AW, n);
    u_mst.bitx(1'b1, n);
    u_mst.bitx(1'b0, n);
    reg_rd(REG_CONFIG, d);
    chk(16'(d), 16'h0008);
    u_mst.start_c();
    u_mst.wbyte(AR, n);
    chk(16'(dat_oe), 16'h0001);
    u_mst.hold_low(250);
    chk(16'(dat_oe), 16'h0000);
    u_mst.stop_c();
    reg_rd(REG_CONFIG, d);
    chk(16'(d), 16'h0008);
    reg_wr(REG_CONFIG, 8'h40);
    for (int k = 0; k < 100 && busy !== 1'b0; k++)
      @(posedge mclk);
    n0 = starts;
    loc_t <= 12'h800;
    repeat (300) @(posedge mclk);
    chk(16'(starts - n0), 16'h0000);
    reg_wr(REG_ONE_SHOT, 8'h5a);
    repeat (300) @(posedge mclk);
    chk(16'(starts - n0), 16'h0001);
    rd_word(REG_LOC_MSB, w);
    chk(w, 16'h8000);
    reg_rd(REG_ONE_SHOT, d);
    chk(16'(d), 16'h0000);
    end_sim();
  end
endmodule

`default_nettype wire
